//--- logic/cbt_exec.sv
// top: executes compact trap, branch and long-branch-with-link.
// assumes the fetch pipeline holds instr until ready is seen and
// applies the one-cycle result pulses to its own register file.
//
// Overview of operation
// - trap switches to 32-bit state, supervisor mode
// - trap saves return, status, jumps to 0x8
// - trap immediate is ignored by hardware
// - compact trap timing equals 32-bit trap
// - branch adds doubled signed 11-bit offset
// - branch base is instruction address plus four
// - first half: link = pc + offset<<12
// - second half: pc = link + offset<<1
// - long branch has own timing, no borrowing
// - condition 1111 is trap, 1110 undefined
`timescale 1ns/1ns
module cbt_exec #(
  parameter int TRAP_CYCLES = cbt_pkg::TRAP_CYCLES_DEFAULT,
  parameter int BRANCH_CYCLES = cbt_pkg::BRANCH_CYCLES_DEFAULT,
  parameter int LONG_CYCLES = cbt_pkg::LONG_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction from fetch
  input wire cbt_pkg::instr_t instr,
  input wire logic [31:0] link_now,
  input wire logic [31:0] status_now,
  // handshake and results
  output logic ready,
  output cbt_pkg::result_t result,
  output logic undef_pulse,
  output logic compact_state,
  output logic [4:0] mode
);
  import cbt_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  op_kind_t kind;
  logic [31:0] target;
  logic [31:0] next_addr;

  cbt_decode u_dec (
    .opcode(instr.opcode),
    .addr(instr.addr),
    .link_now(link_now),
    .kind(kind),
    .target(target),
    .next_addr(next_addr)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } state_t;

  state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  result_t pend_q, pend_d;
  result_t result_q, result_d;
  logic ready_q, ready_d;
  logic undef_q, undef_d;
  logic compact_q, compact_d;
  logic [4:0] mode_q, mode_d;

  // trap and branch reuse 32-bit timings; long branch uses its own
  wire logic [7:0] cycles_of =
    (kind == OP_TRAP) ? 8'(TRAP_CYCLES) :
    (kind == OP_BRANCH) ? 8'(BRANCH_CYCLES) :
    8'(LONG_CYCLES);
  wire logic acts = kind != OP_NONE && kind != OP_UNDEF;
  wire logic is_trap = kind == OP_TRAP;
  wire logic one_shot = cycles_of <= 8'h01;
  wire logic [31:0] status_trap =
    {status_now[31:6], 1'b0, MODE_SUPERVISOR};
  wire logic [31:0] link_return = {next_addr[31:1], 1'b1};

  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // fetch keeps valid up through the ready cycle, so the answered
  // instruction must not be taken a second time there
  wire logic answered = ready_q;
  wire logic take =
    instr.valid && state_q == ST_IDLE && compact_q && !answered;
  wire logic start = take && acts;

  result_t new_res;
  always_comb begin
    new_res = '0;
    unique case (kind)
      OP_TRAP: begin
        new_res.pc_load = 1'b1;
        new_res.pc = target;
        new_res.link_load = 1'b1;
        new_res.link = next_addr;
        new_res.saved_load = 1'b1;
        new_res.saved = status_now;
        new_res.status_load = 1'b1;
        new_res.status = status_trap;
      end
      OP_BRANCH: begin
        new_res.pc_load = 1'b1;
        new_res.pc = target;
      end
      OP_LONG_HI: begin
        new_res.link_load = 1'b1;
        new_res.link = target;
      end
      OP_LONG_LO: begin
        new_res.pc_load = 1'b1;
        new_res.pc = target;
        new_res.link_load = 1'b1;
        new_res.link = link_return;
      end
      OP_NONE, OP_UNDEF: begin
        new_res = '0;
      end
      default: begin
        new_res = '0;
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    result_d = '0;
    ready_d = 1'b0;
    undef_d = 1'b0;
    compact_d = compact_q;
    mode_d = mode_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          pend_d = new_res;
          cnt_d = cycles_of;
          if (one_shot) begin
            result_d = new_res;
            ready_d = 1'b1;
            if (is_trap) begin
              compact_d = 1'b0;
              mode_d = MODE_SUPERVISOR;
            end
          end else begin
            state_d = ST_BUSY;
          end
        end else if (take) begin
          ready_d = 1'b1;
          undef_d = kind == OP_UNDEF;
        end
      end
      ST_BUSY: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h02) begin
          state_d = ST_IDLE;
          result_d = pend_q;
          ready_d = 1'b1;
          if (pend_q.status_load) begin
            compact_d = 1'b0;
            mode_d = MODE_SUPERVISOR;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // sequencing state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      pend_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
    end
  end

  // one-cycle answer to fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
      ready_q <= 1'b0;
      undef_q <= 1'b0;
    end else begin
      result_q <= result_d;
      ready_q <= ready_d;
      undef_q <= undef_d;
    end
  end

  // only reset brings back compact state after a trap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compact_q <= 1'b1;
      mode_q <= MODE_RESET;
    end else begin
      compact_q <= compact_d;
      mode_q <= mode_d;
    end
  end

  // outputs straight from flops
  assign ready = ready_q;
  assign result = result_q;
  assign undef_pulse = undef_q;
  assign compact_state = compact_q;
  assign mode = mode_q;

endmodule : cbt_exec

//--- logic/cbt_pkg.sv
// package: encodings, vectors, mode codes and carriers for the
// compact branch/trap execution unit.
// assumes a 32-bit address space and 16-bit compact instructions.
package cbt_pkg;

  // ----------------------------------------
  // encodings and constants
  // ----------------------------------------
  localparam logic [31:0] TRAP_VECTOR = 32'h0000_0008;
  localparam logic [31:0] PREFETCH_AHEAD = 32'h0000_0004;
  localparam logic [31:0] HALF_STEP = 32'h0000_0002;
  localparam logic [4:0] MODE_SUPERVISOR = 5'h13;
  localparam logic [4:0] MODE_RESET = 5'h13;
  localparam int STATE_BIT = 5;
  localparam int MODE_LSB = 0;
  localparam logic [3:0] OP_COND_BRANCH = 4'hD;
  localparam logic [4:0] OP_UNCOND = 5'h1C;
  localparam logic [3:0] OP_LONG = 4'hF;
  localparam logic [3:0] COND_TRAP = 4'hF;
  localparam logic [3:0] COND_UNDEF = 4'hE;
  localparam int LONG_HI_SHIFT = 12;
  localparam int HALF_SHIFT = 1;
  // trap cycles follow the 32-bit trap; parameterised in the top
  localparam int TRAP_CYCLES_DEFAULT = 3;
  localparam int BRANCH_CYCLES_DEFAULT = 3;
  localparam int LONG_CYCLES_DEFAULT = 1;
  localparam logic [31:0] STATUS_RESET = 32'h0000_00D3;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [31:0] addr;
  } instr_t;

  typedef struct packed {
    logic pc_load;
    logic [31:0] pc;
    logic link_load;
    logic [31:0] link;
    logic status_load;
    logic [31:0] status;
    logic saved_load;
    logic [31:0] saved;
  } result_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_TRAP = 3'b001,
    OP_BRANCH = 3'b010,
    OP_LONG_HI = 3'b011,
    OP_LONG_LO = 3'b100,
    OP_UNDEF = 3'b101
  } op_kind_t;

endpackage : cbt_pkg

//--- logic/cbt_decode.sv
// decoder: classifies a compact instruction and computes its targets.
// assumes addr is the address of the instruction being decoded.
`timescale 1ns/1ns
module cbt_decode (
  // instruction in
  input wire logic [15:0] opcode,
  input wire logic [31:0] addr,
  input wire logic [31:0] link_now,
  // decode out
  output cbt_pkg::op_kind_t kind,
  output logic [31:0] target,
  output logic [31:0] next_addr
);
  import cbt_pkg::*;

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire logic [3:0] cond = opcode[11:8];
  wire logic [10:0] off11 = opcode[10:0];
  // sign extension before scaling keeps backward targets right
  wire logic [31:0] off_br = {{20{off11[10]}}, off11, 1'b0};
  wire logic [31:0] off_hi = {{9{off11[10]}}, off11, 12'h000};
  wire logic [31:0] off_lo = {20'h00000, off11, 1'b0};
  wire logic [31:0] pc_view = addr + PREFETCH_AHEAD;
  wire logic is_cond = opcode[15:12] == OP_COND_BRANCH;
  wire logic is_unc = opcode[15:11] == OP_UNCOND;
  wire logic is_long = opcode[15:12] == OP_LONG;

  // ----------------------------------------
  // classification
  // ----------------------------------------
  // trap_immediate (opcode[7:0]) is deliberately never read
  assign kind = (is_cond && cond == COND_TRAP) ? OP_TRAP :
                (is_cond && cond == COND_UNDEF) ? OP_UNDEF :
                is_unc ? OP_BRANCH :
                (is_long && !opcode[11]) ? OP_LONG_HI :
                (is_long && opcode[11]) ? OP_LONG_LO : OP_NONE;

  assign target = (kind == OP_TRAP) ? TRAP_VECTOR :
                  (kind == OP_BRANCH) ? pc_view + off_br :
                  (kind == OP_LONG_HI) ? pc_view + off_hi :
                  (kind == OP_LONG_LO) ? link_now + off_lo :
                  32'h0000_0000;
  assign next_addr = addr + HALF_STEP;

endmodule : cbt_decode

//--- tb/cbt_exec_monitor.sv
// checker: results of trap, branch and long branch at ready.
// assumes fetch holds instr and link_now steady through ready.
`timescale 1ns/1ns
module cbt_exec_monitor #(
  parameter int TRAP_CYCLES = 3,
  parameter int BRANCH_CYCLES = 3,
  parameter int LONG_CYCLES = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fetch side
  input wire cbt_pkg::instr_t instr,
  input wire logic [31:0] link_now,
  input wire logic [31:0] status_now,
  // results
  input wire logic ready,
  input wire cbt_pkg::result_t result,
  input wire logic undef_pulse,
  input wire logic compact_state,
  input wire logic [4:0] mode
);
  import cbt_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [15:0] op = instr.opcode;
  wire logic [31:0] base = instr.addr + PREFETCH_AHEAD;
  wire logic sx = op[10];
  wire logic tr = ready && op[15:8] == 8'hDF;
  sequence s_trap_take;
    $rose(instr.valid) && op[15:8] == 8'hDF;
  endsequence
  sequence s_trap_done;
    !ready [*2] ##[1:3] ready;
  endsequence
  property p_trap_time;
    s_trap_take |-> s_trap_done;
  endproperty
  a_trap_time: assert property (p_trap_time)
    else $error("trap answer timing wrong");
  property p_long_time;
    $rose(instr.valid) && op[15:12] == OP_LONG |-> ##[1:2] ready;
  endproperty
  a_long_time: assert property (p_long_time)
    else $error("long branch answer late");
  property p_trap_vec;
    tr |-> result.pc_load && result.pc == TRAP_VECTOR;
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector wrong");
  property p_trap_save;
    tr |-> result.saved == status_now && result.link == instr.addr + 32'h2;
  endproperty
  a_trap_save: assert property (p_trap_save)
    else $error("trap save wrong");
  property p_trap_state;
    tr |=> !compact_state && mode == MODE_SUPERVISOR;
  endproperty
  a_trap_state: assert property (p_trap_state)
    else $error("trap state or mode wrong");
  property p_branch;
    ready && op[15:11] == OP_UNCOND |->
      result.pc == base + {{20{sx}}, op[10:0], 1'b0};
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");
  property p_long_hi;
    ready && op[15:11] == 5'h1E |->
      result.link == base + {{9{sx}}, op[10:0], 12'h000};
  endproperty
  a_long_hi: assert property (p_long_hi)
    else $error("long upper link wrong");
  property p_long_lo;
    ready && op[15:11] == 5'h1F |->
      result.pc == link_now + {20'h0, op[10:0], 1'b0}
      && result.link == ((instr.addr + 32'h2) | 32'h1);
  endproperty
  a_long_lo: assert property (p_long_lo)
    else $error("long lower result wrong");
  property p_undef;
    ready && op[15:8] == 8'hDE |-> undef_pulse && !result.pc_load;
  endproperty
  a_undef: assert property (p_undef)
    else $error("undefined code not flagged");
  property p_ready_pulse;
    ready |=> !ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held more than one cycle");
endmodule : cbt_exec_monitor
bind cbt_exec cbt_exec_monitor #(.TRAP_CYCLES(TRAP_CYCLES),
  .BRANCH_CYCLES(BRANCH_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_mon (
  .clk(clk), .rst_n(rst_n), .instr(instr), .link_now(link_now),
  .status_now(status_now), .ready(ready), .result(result),
  .undef_pulse(undef_pulse), .compact_state(compact_state), .mode(mode));

//--- tb/cbt_fetch_model.sv
// fetch model: presents one instruction and holds it until ready.
// assumes go pulses one cycle, only while the unit is idle.
`timescale 1ns/1ns
module cbt_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from bench
  input wire logic go,
  input wire logic [15:0] op,
  input wire logic [31:0] addr,
  // unit side
  output cbt_pkg::instr_t instr,
  output logic [31:0] link_now,
  input wire logic ready,
  input wire cbt_pkg::result_t result
);
  import cbt_pkg::*;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr <= '0;
      link_now <= 32'h0;
    end else if (go) begin
      instr <= '{1'b1, op, addr};
    end else if (ready) begin
      // released lines show no stale value
      instr <= '{1'b0, ~instr.opcode, ~instr.addr};
      if (result.link_load) begin
        link_now <= result.link;
      end
    end
  end
endmodule : cbt_fetch_model

//--- tb/tb_top.sv
// bench: table of branch cases, then undefined, trap and reset.
// assumes the fetch model feeds the unit and updates its link.
`timescale 1ns/1ns
module tb_top;
  import cbt_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] a, p, l;
    logic [1:0] s;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [15:0] op = 16'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] status_now = 32'hF0;
  instr_t instr;
  logic [31:0] link_now;
  logic ready, undef_pulse, compact_state, u;
  logic [4:0] mode;
  result_t result, r;
  int mismatches = 0;
  int n_tests = 0;
  // encodings keep targets halfword aligned, second upper half paired with the lower half
  row_t rows[6] = '{
    '{16'hE7FE, 32'h100, 32'h100, 32'h0, 2'h1},
    '{16'hE3FF, 32'h100, 32'h902, 32'h0, 2'h1},
    '{16'hE400, 32'h1000, 32'h804, 32'h0, 2'h1},
    '{16'hF7FF, 32'h2000, 32'h0, 32'h1004, 2'h2},
    '{16'hF001, 32'h2000, 32'h0, 32'h3004, 2'h2},
    '{16'hF803, 32'h2002, 32'h300A, 32'h2005, 2'h3}};
  cbt_fetch_model u_cbt_fetch_model (.clk(clk), .rst_n(rst_n),
    .go(go), .op(op), .addr(addr), .instr(instr),
    .link_now(link_now), .ready(ready), .result(result));
  cbt_exec #(.TRAP_CYCLES(3), .BRANCH_CYCLES(3), .LONG_CYCLES(1))
    u_cbt_exec (.clk(clk), .rst_n(rst_n), .instr(instr),
    .link_now(link_now), .status_now(status_now), .ready(ready),
    .result(result), .undef_pulse(undef_pulse),
    .compact_state(compact_state), .mode(mode));
  task automatic final_report;
    $display("mismatches %0d tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [31:0] loads(input result_t x);
    return {28'h0, x.pc_load, x.link_load, x.status_load, x.saved_load};
  endfunction : loads
  task automatic run(input logic [15:0] o, input logic [31:0] a);
    int k;
    op = o;
    addr = a;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    for (k = 0; k < 12; k++) begin
      @(negedge clk);
      if (ready === 1'b1) break;
    end
    r = result;
    u = undef_pulse;
    if (k == 12) begin
      mismatches++;
      final_report();
    end
    @(posedge clk);
    #1;
  endtask : run
  initial forever #5 clk = ~clk;
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].s[0]) run(rows[i].op, rows[i].a);
      if (rows[i].s[0]) chk("pc", rows[i].p, r.pc);
      if (!rows[i].s[0]) run(rows[i].op, rows[i].a);
      if (rows[i].s[1]) chk("link", rows[i].l, r.link);
    end
    run(16'hDE12, 32'h300);
    chk("undef", 32'h1, {31'h0, u});
    chk("undef_loads", 32'h0, loads(r));
    run(16'hD012, 32'h500);
    chk("cond_undef", 32'h0, {31'h0, u});
    chk("cond_loads", 32'h0, loads(r));
    run(16'hDF12, 32'h400);
    chk("trap_loads", 32'hF, loads(r));
    chk("trap_pc", TRAP_VECTOR, r.pc);
    chk("trap_link", 32'h402, r.link);
    chk("saved", status_now, r.saved);
    chk("status", 32'hD3, r.status);
    chk("mode", 32'h13, {27'h0, mode});
    chk("state", 32'h0, {31'h0, compact_state});
    rst_n = 1'b0;
    @(posedge clk);
    #1 chk("rst_state", 32'h1, {31'h0, compact_state});
    rst_n = 1'b1;
    status_now = 32'h0000_0030;
    // other immediate, same outcome
    run(16'hDFAB, 32'h400);
    chk("imm_pc", TRAP_VECTOR, r.pc);
    chk("imm_link", 32'h402, r.link);
    chk("imm_saved", 32'h30, r.saved);
    chk("imm_status", 32'h13, r.status);
    final_report();
  end
endmodule : tb_top
